// ==== bench/testbench.sv ====
/* Self-checking bench for rbs_core: table of register writes and reads,
   then bank, stack, flag, program counter and mid-run reset cases.
   Assumes the one-cycle register port and the offsets of the core. */
`timescale 1ns/1ps
module testbench;
  logic clk, rst_b, reg_wr, reg_rd, alu_valid, alu_wide, alu_carry, alu_overflow, pc_advance;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  rbs_pkg::rbs_alu_kind_type alu_kind;
  logic [15:0] alu_result, static_base, stack_pointer;
  logic [2:0] pc_step;
  logic [19:0] next_instruction_address, vector_table_base;
  logic [10:0] cpu_status_word;
  int error_cnt = 0;
  int check_count = 0;
  // Rows: write offset, write data, read offset, expected read word
  logic [4:0] wa [9] = '{5'h00, 5'h04, 5'h08, 5'h09, 5'h0c, 5'h0d, 5'h0e, 5'h13, 5'h15};
  logic [31:0] wd [9] = '{32'h1234abcd, 32'h000000ef, 32'h55556666, 32'h77778888,
    32'h11112222, 32'h00003344, 32'hffffffff, 32'hffff1357, 32'h00000001};
  logic [4:0] ra [9] = '{5'h05, 5'h00, 5'h02, 5'h03, 5'h0b, 5'h0d, 5'h0e, 5'h13, 5'h15};
  logic [31:0] re [9] = '{32'h000000ab, 32'h0000abef, 32'h00005555, 32'h00007777,
    32'h00001111, 32'h00003344, 32'h000fffff, 32'h00001357, 32'h00000000};

  rbs_core DUT (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alu_valid,
    .alu_kind, .alu_wide, .alu_result, .alu_carry, .alu_overflow, .pc_advance, .pc_step,
    .next_instruction_address, .vector_table_base, .static_base, .stack_pointer,
    .cpu_status_word);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobes drop one edge after rising, so calls never collide
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [4:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic alu(rbs_pkg::rbs_alu_kind_type k, logic w, logic [15:0] r, logic c, logic o,
    logic [10:0] e);
    @(posedge clk);
    alu_valid <= 1'b1;
    alu_kind <= k;
    alu_wide <= w;
    alu_result <= r;
    alu_carry <= c;
    alu_overflow <= o;
    @(posedge clk);
    alu_valid <= 1'b0;
    #1;
    chk("cpu_status_word", {21'h000000, cpu_status_word}, {21'h000000, e});
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Fixed waits only, so a hang can only come from the run itself
  initial begin
    #40000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, alu_valid, alu_wide, alu_carry, alu_overflow, pc_advance} = '0;
    {reg_addr, reg_wdata, alu_result, pc_step} = '0;
    alu_kind = rbs_pkg::ALU_ARITH;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      wr(wa[i], wd[i]);
      rd(ra[i], re[i]);
    end
    chk("vector_table_base", {12'h000, vector_table_base}, 32'h000fffff);
    chk("static_base", {16'h0000, static_base}, 32'h00001357);
    wr(5'h14, 32'h00000010);
    wr(5'h00, 32'h00009999);
    rd(5'h00, 32'h00009999);
    wr(5'h14, 32'h00000000);
    // The pair write of row 2 left its lower half in the first data register
    rd(5'h00, 32'h00006666);
    // Write then read with no gap between the strobes
    @(posedge clk);
    reg_addr <= 5'h00;
    reg_wdata <= 32'h00004321;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, 32'h00004321);
    wr(5'h10, 32'h00000aaa);
    wr(5'h11, 32'h00000bbb);
    chk("stack_pointer", {16'h0000, stack_pointer}, 32'h00000bbb);
    wr(5'h14, 32'h00000080);
    chk("stack_pointer", {16'h0000, stack_pointer}, 32'h00000aaa);
    rd(5'h12, 32'h00000aaa);
    wr(5'h14, 32'h00000000);
    alu(rbs_pkg::ALU_ARITH, 1'b1, 16'h0000, 1'b1, 1'b0, 11'h005);
    alu(rbs_pkg::ALU_ARITH, 1'b1, 16'h8000, 1'b0, 1'b1, 11'h028);
    alu(rbs_pkg::ALU_LOGIC, 1'b1, 16'h0000, 1'b0, 1'b0, 11'h008);
    alu(rbs_pkg::ALU_SHIFT, 1'b1, 16'h1234, 1'b1, 1'b0, 11'h009);
    alu(rbs_pkg::ALU_ARITH, 1'b0, 16'h0100, 1'b0, 1'b0, 11'h004);
    rd(5'h14, 32'h00000004);
    wr(5'h0f, 32'h000fffff);
    @(posedge clk);
    pc_advance <= 1'b1;
    pc_step <= 3'h3;
    @(posedge clk);
    pc_advance <= 1'b0;
    #1;
    chk("pc", {12'h000, next_instruction_address}, 32'h00000002);
    // Reset in mid-run must clear the word while the bank bit is set
    // Status writes load the debug bit from bit 1 of the write data
    wr(5'h14, 32'h00000010);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk("cpu_status_word", {21'h000000, cpu_status_word}, 32'h00000000);
    // Second release: first data register, status word and program counter must come back cleared
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(5'h00, 32'h00000000);
    rd(5'h14, 32'h00000000);
    chk("pc", {12'h000, next_instruction_address}, 32'h00000000);
    wrap_up();
  end
endmodule // testbench

// ==== verilog/rbs_bank_store.sv ====
/*
 * Two banks of 16-bit entries for the data, address and frame base
 * registers, two write ports and a formatted, registered read word.
 * Assumes one clock, a synchronised active-low reset, one bank bit.
 */
`timescale 1ns/1ps
module rbs_bank_store #(
  parameter int ENTRIES = 8 // Entries per bank
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset
  input wire logic bank, // Selected bank
  input wire logic wr_a_en, // Write port a strobe
  input wire logic [rbs_pkg::IDX_W-1:0] wr_a_idx, // Port a entry
  input wire logic [1:0] wr_a_mask, // Port a byte lanes
  input wire logic [rbs_pkg::WORD_W-1:0] wr_a_data, // Port a data
  input wire logic wr_b_en, // Write port b strobe (upper half)
  input wire logic [rbs_pkg::IDX_W-1:0] wr_b_idx, // Port b entry
  input wire logic [rbs_pkg::WORD_W-1:0] wr_b_data, // Port b data
  input wire logic rd_en, // Read strobe
  input wire logic [rbs_pkg::IDX_W-1:0] rd_a_idx, // Lower word entry
  input wire logic [rbs_pkg::IDX_W-1:0] rd_b_idx, // Upper word entry
  input wire rbs_pkg::rbs_fmt_type rd_fmt, // Read word layout
  input wire logic [rbs_pkg::BUS_W-1:0] bypass_data, // Unbanked word
  output logic [rbs_pkg::BUS_W-1:0] rd_data // Registered read word
);
  localparam int DEPTH = 2 * ENTRIES;
  localparam int AW = $clog2(DEPTH);
  logic [rbs_pkg::WORD_W-1:0] mem_reg [DEPTH];
  logic [rbs_pkg::BUS_W-1:0] rd_next;
  wire [AW-1:0] loc_wa = {bank, wr_a_idx};
  wire [AW-1:0] loc_wb = {bank, wr_b_idx};
  wire [rbs_pkg::WORD_W-1:0] word_a = mem_reg[{bank, rd_a_idx}];
  wire [rbs_pkg::WORD_W-1:0] word_b = mem_reg[{bank, rd_b_idx}];

  // One entry per loop pass; port b only ever hits a different entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_reg[g] <= rbs_pkg::WORD_RESET;
      end else if (wr_b_en && loc_wb == AW'(g)) begin
        mem_reg[g] <= wr_b_data;
      end else if (wr_a_en && loc_wa == AW'(g)) begin
        if (wr_a_mask[0]) mem_reg[g][7:0] <= wr_a_data[7:0];
        if (wr_a_mask[1]) mem_reg[g][15:8] <= wr_a_data[15:8];
      end
    end
  end

  // Read layout: byte views sit in the low bits, pairs upper half first
  assign rd_next = (rd_fmt == rbs_pkg::FMT_WORD) ? {16'h0000, word_a} :
    (rd_fmt == rbs_pkg::FMT_LOW) ? {24'h000000, word_a[7:0]} :
    (rd_fmt == rbs_pkg::FMT_HIGH) ? {24'h000000, word_a[15:8]} :
    (rd_fmt == rbs_pkg::FMT_PAIR) ? {word_b, word_a} : bypass_data;

  // Read word register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= rbs_pkg::BUS_ZERO;
    end else if (rd_en) begin
      rd_data <= rd_next;
    end
  end
endmodule // rbs_bank_store

// ==== verilog/rbs_core.sv ====
/*
 * Banked CPU register set: two banks of data, address and frame
 * base registers, pointers, stack pointers, static base and the
 * status word, reached over a plain register port.
 * Assumes the execution unit reports ALU results and PC steps on
 * the same clock; the register port never waits.
 */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module rbs_core #(
  parameter int BANK_ENTRIES = 8 // Entries per bank, seven used
) (
  input wire logic clk, // 250 MHz core clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [rbs_pkg::ADDR_W-1:0] reg_addr, // Register offset
  input wire logic [rbs_pkg::BUS_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [rbs_pkg::BUS_W-1:0] reg_rdata, // Read data, next cycle
  input wire logic alu_valid, // Result report strobe
  input wire rbs_pkg::rbs_alu_kind_type alu_kind, // Operation class
  input wire logic alu_wide, // Word (1) or byte (0) result
  input wire logic [rbs_pkg::WORD_W-1:0] alu_result, // Result value
  input wire logic alu_carry, // Carry out of the operation
  input wire logic alu_overflow, // Overflow of the operation
  input wire logic pc_advance, // Step the program counter
  input wire logic [2:0] pc_step, // Bytes to step by
  output logic [rbs_pkg::PTR_W-1:0] next_instruction_address, // PC
  output logic [rbs_pkg::PTR_W-1:0] vector_table_base, // Vector base
  output logic [rbs_pkg::WORD_W-1:0] static_base, // Static base
  output logic [rbs_pkg::WORD_W-1:0] stack_pointer, // Active stack ptr
  output logic [rbs_pkg::FLAG_W-1:0] cpu_status_word // Status word
);

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic rst_meta_reg;
  logic rst_n;

  // Release is synchronised so no flop leaves reset on a split edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Register state outside the banks
  // ****************************************************************

  logic [rbs_pkg::PTR_W-1:0] pc_reg;
  logic [rbs_pkg::PTR_W-1:0] pc_next;
  logic [rbs_pkg::PTR_W-1:0] vtb_reg;
  logic [rbs_pkg::PTR_W-1:0] vtb_next;
  logic [rbs_pkg::WORD_W-1:0] usp_reg;
  logic [rbs_pkg::WORD_W-1:0] usp_next;
  logic [rbs_pkg::WORD_W-1:0] isp_reg;
  logic [rbs_pkg::WORD_W-1:0] isp_next;
  logic [rbs_pkg::WORD_W-1:0] sb_reg;
  logic [rbs_pkg::WORD_W-1:0] sb_next;
  logic [rbs_pkg::WORD_W-1:0] sp_reg;
  logic [rbs_pkg::WORD_W-1:0] sp_next;
  logic [rbs_pkg::FLAG_W-1:0] flag_reg;
  logic [rbs_pkg::FLAG_W-1:0] flag_base;
  logic [rbs_pkg::FLAG_W-1:0] flag_next;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Named hits for each banked target, views folded onto their entry
  wire hit_first_lo = reg_addr == rbs_pkg::OFF_FIRST_LOW_BYTE;
  wire hit_first_hi = reg_addr == rbs_pkg::OFF_FIRST_HIGH_BYTE;
  wire hit_second_lo = reg_addr == rbs_pkg::OFF_SECOND_LOW_BYTE;
  wire hit_second_hi = reg_addr == rbs_pkg::OFF_SECOND_HIGH_BYTE;
  wire hit_first = reg_addr == rbs_pkg::OFF_DATA_FIRST;
  wire hit_second = reg_addr == rbs_pkg::OFF_DATA_SECOND;
  wire hit_third = reg_addr == rbs_pkg::OFF_DATA_THIRD;
  wire hit_fourth = reg_addr == rbs_pkg::OFF_DATA_FOURTH;
  wire hit_dpl = reg_addr == rbs_pkg::OFF_DATA_PAIR_LOW;
  wire hit_dph = reg_addr == rbs_pkg::OFF_DATA_PAIR_HIGH;
  wire hit_a0 = reg_addr == rbs_pkg::OFF_ADDR_FIRST;
  wire hit_a1 = reg_addr == rbs_pkg::OFF_ADDR_SECOND;
  wire hit_ap = reg_addr == rbs_pkg::OFF_ADDR_PAIR;
  wire hit_fb = reg_addr == rbs_pkg::OFF_FRAME_BASE;
  wire hit_vtb = reg_addr == rbs_pkg::OFF_VECTOR_BASE;
  wire hit_pc = reg_addr == rbs_pkg::OFF_NEXT_INSTR;
  wire hit_usp = reg_addr == rbs_pkg::OFF_USER_SP;
  wire hit_isp = reg_addr == rbs_pkg::OFF_INTR_SP;
  wire hit_asp = reg_addr == rbs_pkg::OFF_ACTIVE_SP;
  wire hit_sb = reg_addr == rbs_pkg::OFF_STATIC_BASE;
  wire hit_flag = reg_addr == rbs_pkg::OFF_STATUS;

  // Grouped views
  wire byte_lo = hit_first_lo || hit_second_lo;
  wire byte_hi = hit_first_hi || hit_second_hi;
  wire is_pair = hit_dpl || hit_dph || hit_ap;
  wire is_word = hit_first || hit_second || hit_third || hit_fourth ||
    hit_a0 || hit_a1 || hit_fb;
  wire banked = is_word || is_pair || byte_lo || byte_hi;

  // Entry for the word or lower half; second data entry takes its byte views and the high data pair
  wire [rbs_pkg::IDX_W-1:0] idx_a =
    (hit_first || hit_first_lo || hit_first_hi || hit_dpl) ?
      rbs_pkg::IDX_DATA_FIRST :
    (hit_second || hit_second_lo || hit_second_hi || hit_dph) ?
      rbs_pkg::IDX_DATA_SECOND :
    hit_third ? rbs_pkg::IDX_DATA_THIRD :
    hit_fourth ? rbs_pkg::IDX_DATA_FOURTH :
    (hit_a0 || hit_ap) ? rbs_pkg::IDX_ADDR_FIRST :
    hit_a1 ? rbs_pkg::IDX_ADDR_SECOND : rbs_pkg::IDX_FRAME_BASE;

  // Entry for the upper half of a pair
  wire [rbs_pkg::IDX_W-1:0] idx_b =
    hit_dpl ? rbs_pkg::IDX_DATA_THIRD :
    hit_dph ? rbs_pkg::IDX_DATA_FOURTH :
    rbs_pkg::IDX_ADDR_SECOND;

  // Byte writes replicate the byte; the mask picks the lane
  wire [1:0] mask_a = byte_lo ? rbs_pkg::MASK_LOW :
    byte_hi ? rbs_pkg::MASK_HIGH : rbs_pkg::MASK_BOTH;
  wire [rbs_pkg::WORD_W-1:0] data_a = (byte_lo || byte_hi) ?
    {reg_wdata[7:0], reg_wdata[7:0]} : reg_wdata[15:0];

  // Read layout for the bank store
  wire rbs_pkg::rbs_fmt_type fmt =
    !banked ? rbs_pkg::FMT_BYPASS :
    is_pair ? rbs_pkg::FMT_PAIR :
    byte_lo ? rbs_pkg::FMT_LOW :
    byte_hi ? rbs_pkg::FMT_HIGH : rbs_pkg::FMT_WORD;

  // Unbanked read word; unmapped offsets read as zero
  wire [rbs_pkg::BUS_W-1:0] bypass =
    hit_vtb ? {12'h000, vtb_reg} :
    hit_pc ? {12'h000, pc_reg} :
    hit_usp ? {16'h0000, usp_reg} :
    hit_isp ? {16'h0000, isp_reg} :
    hit_asp ? {16'h0000, sp_reg} :
    hit_sb ? {16'h0000, sb_reg} :
    hit_flag ? {21'h000000, flag_reg} : rbs_pkg::BUS_ZERO;

  // Write enables for the unbanked registers
  wire wr_vtb = reg_wr && hit_vtb;
  wire wr_pc = reg_wr && hit_pc;
  wire wr_sb = reg_wr && hit_sb;
  wire wr_flag = reg_wr && hit_flag;
  wire use_usp = flag_reg[rbs_pkg::FLAG_STACK];
  wire wr_usp = reg_wr && (hit_usp || (hit_asp && use_usp));
  wire wr_isp = reg_wr && (hit_isp || (hit_asp && !use_usp));

  // ****************************************************************
  // Banked store
  // ****************************************************************

  // The store's read register is the port's read data flop
  rbs_bank_store #(
    .ENTRIES(BANK_ENTRIES)
  ) u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .bank(flag_reg[rbs_pkg::FLAG_BANK]),
    .wr_a_en(reg_wr && banked),
    .wr_a_idx(idx_a),
    .wr_a_mask(mask_a),
    .wr_a_data(data_a),
    .wr_b_en(reg_wr && is_pair),
    .wr_b_idx(idx_b),
    .wr_b_data(reg_wdata[31:16]),
    .rd_en(reg_rd),
    .rd_a_idx(idx_a),
    .rd_b_idx(idx_b),
    .rd_fmt(fmt),
    .bypass_data(bypass),
    .rd_data(reg_rdata)
  );

  // ****************************************************************
  // Status word
  // ****************************************************************

  // A same-cycle ALU report lands on top of a software write, so a
  // result is never lost to a status store
  assign flag_base = wr_flag ? reg_wdata[rbs_pkg::FLAG_W-1:0] : flag_reg;

  rbs_flag_calc u_flag (
    .cur(flag_base),
    .valid(alu_valid),
    .kind(alu_kind),
    .wide(alu_wide),
    .result(alu_result),
    .carry(alu_carry),
    .overflow(alu_overflow),
    .nxt(flag_next)
  );

  // ****************************************************************
  // Pointer next values
  // ****************************************************************

  // A written address beats a step in the same cycle (a jump wins)
  assign pc_next = wr_pc ? reg_wdata[rbs_pkg::PTR_W-1:0] :
    pc_advance ? pc_reg + rbs_pkg::PTR_W'(pc_step) : pc_reg;
  assign vtb_next = wr_vtb ? reg_wdata[rbs_pkg::PTR_W-1:0] : vtb_reg;
  assign sb_next = wr_sb ? reg_wdata[rbs_pkg::WORD_W-1:0] : sb_reg;
  assign usp_next = wr_usp ? reg_wdata[rbs_pkg::WORD_W-1:0] : usp_reg;
  assign isp_next = wr_isp ? reg_wdata[rbs_pkg::WORD_W-1:0] : isp_reg;

  // Active pointer follows the stack flag it will see next cycle
  assign sp_next = flag_next[rbs_pkg::FLAG_STACK] ? usp_next : isp_next;

  // ****************************************************************
  // State registers
  // ****************************************************************

  // Status word, cleared on reset so bank 0 is in use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= rbs_pkg::FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Program counter and vector table base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= rbs_pkg::PTR_RESET;
      vtb_reg <= rbs_pkg::PTR_RESET;
    end else begin
      pc_reg <= pc_next;
      vtb_reg <= vtb_next;
    end
  end

  // Stack pointers and static base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usp_reg <= rbs_pkg::WORD_RESET;
      isp_reg <= rbs_pkg::WORD_RESET;
      sp_reg <= rbs_pkg::WORD_RESET;
      sb_reg <= rbs_pkg::WORD_RESET;
    end else begin
      usp_reg <= usp_next;
      isp_reg <= isp_next;
      sp_reg <= sp_next;
      sb_reg <= sb_next;
    end
  end

  // Outputs come straight from the state flops
  assign next_instruction_address = pc_reg;
  assign vector_table_base = vtb_reg;
  assign static_base = sb_reg;
  assign stack_pointer = sp_reg;
  assign cpu_status_word = flag_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_word_wr;
    reg_wr && reg_addr == rbs_pkg::OFF_DATA_FIRST;
  endsequence

  sequence s_word_rd;
    reg_rd && reg_addr == rbs_pkg::OFF_DATA_FIRST;
  endsequence

  property p_bank_readback;
    s_word_wr ##1 s_word_rd |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2);
  endproperty
  a_bank_readback: assert property (p_bank_readback)
    else $error("Banked word did not read back");

  property p_status_read;
    reg_rd && hit_flag |=> reg_rdata == {21'h000000, $past(flag_reg)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status word read wrong");

  property p_zero_flag;
    alu_valid && alu_kind == rbs_pkg::ALU_ARITH && alu_wide
      |=> flag_reg[rbs_pkg::FLAG_ZERO] == ($past(alu_result) == 16'h0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("Zero flag wrong after arithmetic");

  property p_sign_flag;
    alu_valid && alu_kind == rbs_pkg::ALU_ARITH && !alu_wide
      |=> flag_reg[rbs_pkg::FLAG_SIGN] == $past(alu_result[7]);
  endproperty
  a_sign_flag: assert property (p_sign_flag)
    else $error("Sign flag wrong after byte arithmetic");

  property p_carry_flag;
    alu_valid |=> cpu_status_word[rbs_pkg::FLAG_CARRY] == $past(alu_carry);
  endproperty
  a_carry_flag: assert property (p_carry_flag)
    else $error("Carry flag not captured");

  property p_overflow_flag;
    alu_valid |=> cpu_status_word[rbs_pkg::FLAG_OVERFLOW] == $past(alu_overflow);
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("Overflow flag not captured");

  property p_stack_select;
    ##1 stack_pointer == (cpu_status_word[rbs_pkg::FLAG_STACK] ? usp_reg : isp_reg);
  endproperty
  a_stack_select: assert property (p_stack_select)
    else $error("Active stack pointer does not match flag");

  property p_pc_step;
    pc_advance && !wr_pc |=> next_instruction_address ==
      $past(pc_reg) + rbs_pkg::PTR_W'($past(pc_step));
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("Program counter did not step");

  property p_reset_flags;
    $rose(rst_n) |-> cpu_status_word == rbs_pkg::FLAG_RESET;
  endproperty
  a_reset_flags: assert property (@(posedge clk) p_reset_flags)
    else $error("Status word not clear after reset");

endmodule // rbs_core

// ==== verilog/rbs_flag_calc.sv ====
/*
 * Combinational status word update from one ALU result report.
 * Assumes the report arrives on the core clock as a single cycle.
 */
`timescale 1ns/1ps
module rbs_flag_calc (
  input wire logic [rbs_pkg::FLAG_W-1:0] cur, // Status before update
  input wire logic valid, // Result report strobe
  input wire rbs_pkg::rbs_alu_kind_type kind, // Operation class
  input wire logic wide, // 1: word result, 0: byte result
  input wire logic [rbs_pkg::WORD_W-1:0] result, // Operation result
  input wire logic carry, // Carry, borrow or shifted-out bit
  input wire logic overflow, // Signed overflow
  output logic [rbs_pkg::FLAG_W-1:0] nxt // Status after update
);
  wire arith = valid && kind == rbs_pkg::ALU_ARITH;
  wire res_zero = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
  wire res_neg = wide ? result[15] : result[7];

  // Only result flags move; bank, stack and debug bits pass through
  always_comb begin
    nxt = cur;
    if (valid) begin
      nxt[rbs_pkg::FLAG_CARRY] = carry;
      nxt[rbs_pkg::FLAG_OVERFLOW] = overflow;
    end
    if (arith) begin
      nxt[rbs_pkg::FLAG_ZERO] = res_zero;
      nxt[rbs_pkg::FLAG_SIGN] = res_neg;
    end
  end
endmodule // rbs_flag_calc

// ==== verilog/rbs_pkg.sv ====
/*
 * Constants for the banked CPU register set: access offsets, bank
 * entry indices, status word field positions, reset values and the
 * enumerations shared by the core, the bank store and the flag unit.
 * Assumes a single 250 MHz clock and a one-cycle register port.
 */
// Notes on behaviour
// - Thirteen registers; data, address and frame base registers exist in two banks.
// - Bank select flag 0 reaches bank 0, flag 1 reaches bank 1.
// - First two data registers are 16 bits and also reachable per byte.
// - Third joins first, fourth joins second, as 32-bit pairs (upper half first).
// - Two 16-bit address registers, also joinable into one 32-bit pair.
// - Frame base is 16 bits and supplies the frame-relative base.
// - Vector table base is 20 bits, start of the interrupt vector table.
// - Program counter is 20 bits and holds the next instruction address.
// - User and interrupt stack pointers, 16 bits; a flag picks the active one.
// - Static base is 16 bits and supplies the static-relative base.
// - Status word is 11 bits with carry, debug, zero, sign, bank, overflow, stack.
// - Carry captures carry, borrow or shifted-out bit of each operation.
// - Arithmetic result zero sets zero flag, else clears it.
// - Arithmetic result negative sets sign flag, else clears it.
// - Overflow flag set on overflow of an operation, else cleared.
package rbs_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int PTR_W = 20;
  localparam int FLAG_W = 11;
  localparam int ADDR_W = 5;
  localparam int BUS_W = 32;
  localparam int IDX_W = 3;

  // ****************************************************************
  // Register port offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_DATA_FIRST = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_DATA_SECOND = 5'h01;
  localparam logic [ADDR_W-1:0] OFF_DATA_THIRD = 5'h02;
  localparam logic [ADDR_W-1:0] OFF_DATA_FOURTH = 5'h03;
  localparam logic [ADDR_W-1:0] OFF_FIRST_LOW_BYTE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_FIRST_HIGH_BYTE = 5'h05;
  localparam logic [ADDR_W-1:0] OFF_SECOND_LOW_BYTE = 5'h06;
  localparam logic [ADDR_W-1:0] OFF_SECOND_HIGH_BYTE = 5'h07;
  localparam logic [ADDR_W-1:0] OFF_DATA_PAIR_LOW = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_DATA_PAIR_HIGH = 5'h09;
  localparam logic [ADDR_W-1:0] OFF_ADDR_FIRST = 5'h0a;
  localparam logic [ADDR_W-1:0] OFF_ADDR_SECOND = 5'h0b;
  localparam logic [ADDR_W-1:0] OFF_ADDR_PAIR = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_FRAME_BASE = 5'h0d;
  localparam logic [ADDR_W-1:0] OFF_VECTOR_BASE = 5'h0e;
  localparam logic [ADDR_W-1:0] OFF_NEXT_INSTR = 5'h0f;
  localparam logic [ADDR_W-1:0] OFF_USER_SP = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_INTR_SP = 5'h11;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE_SP = 5'h12;
  localparam logic [ADDR_W-1:0] OFF_STATIC_BASE = 5'h13;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;

  // ****************************************************************
  // Bank entry indices and byte masks
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_DATA_FIRST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_DATA_SECOND = 3'h1;
  localparam logic [IDX_W-1:0] IDX_DATA_THIRD = 3'h2;
  localparam logic [IDX_W-1:0] IDX_DATA_FOURTH = 3'h3;
  localparam logic [IDX_W-1:0] IDX_ADDR_FIRST = 3'h4;
  localparam logic [IDX_W-1:0] IDX_ADDR_SECOND = 3'h5;
  localparam logic [IDX_W-1:0] IDX_FRAME_BASE = 3'h6;
  localparam logic [1:0] MASK_LOW = 2'h1;
  localparam logic [1:0] MASK_HIGH = 2'h2;
  localparam logic [1:0] MASK_BOTH = 2'h3;

  // ****************************************************************
  // Status word fields and reset values
  // ****************************************************************
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DEBUG = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SIGN = 3;
  localparam int FLAG_BANK = 4;
  localparam int FLAG_OVERFLOW = 5;
  localparam int FLAG_STACK = 7;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 11'h000;
  localparam logic [PTR_W-1:0] PTR_RESET = 20'h00000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [BUS_W-1:0] BUS_ZERO = 32'h00000000;

  typedef enum logic [1:0] {ALU_ARITH, ALU_LOGIC, ALU_SHIFT} rbs_alu_kind_type;
  typedef enum logic [2:0] {FMT_BYPASS, FMT_WORD, FMT_LOW, FMT_HIGH, FMT_PAIR} rbs_fmt_type;

endpackage
